// ===== design/pacc_pkg.sv
// package for the pulse accumulator: register offsets, field positions, reset values
// assumes a byte-wide register port with read data one cycle after the read strobe
package pacc_pkg;

	// register offsets on the plain register port
	localparam logic [1:0] PACC_OFF_CONTROL = 2'h0;
	localparam logic [1:0] PACC_OFF_COUNT   = 2'h1;
	localparam logic [1:0] PACC_OFF_MASK    = 2'h2;
	localparam logic [1:0] PACC_OFF_FLAG    = 2'h3;

	// accumulator_control field positions
	localparam int PACC_CTL_ENABLE_BIT = 6;
	localparam int PACC_CTL_MODE_BIT   = 5;
	localparam int PACC_CTL_EDGE_BIT   = 4;
	localparam int PACC_CTL_CCSEL_BIT  = 2;

	// mask and flag field positions, same place in both registers
	localparam int PACC_OVF_BIT  = 5;
	localparam int PACC_EDGE_BIT = 4;

	// writable bits of each register, others read as zero
	localparam logic [7:0] PACC_CTL_WMASK  = 8'h74;
	localparam logic [7:0] PACC_MASK_WMASK = 8'h30;

	// reset values
	localparam logic [7:0] PACC_CTL_RESET  = 8'h00;
	localparam logic [7:0] PACC_MASK_RESET = 8'h00;
	localparam logic [7:0] PACC_ZERO_BYTE  = 8'h00;

	// gated tick divider
	localparam int         PACC_GATE_DIV   = 64;
	localparam logic [5:0] PACC_DIV_LAST   = 6'(PACC_GATE_DIV - 1);
	localparam logic [7:0] PACC_COUNT_MAX  = 8'hFF;

	typedef struct packed {
		logic [1:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} pacc_bus_req_t;

	typedef struct packed {
		logic       ctl_enable;
		logic       ctl_mode;
		logic       ctl_edge;
		logic       ctl_ccsel;
		logic       irq_ovf_en;
		logic       irq_edge_en;
		logic       flag_ovf;
		logic       flag_edge;
		logic [7:0] count;
		logic [5:0] div;
		logic       pin_meta;
		logic       pin_sync;
		logic       pin_prev;
		logic [7:0] rdata;
	} pacc_state_t;

endpackage : pacc_pkg

// ===== design/pacc_top.sv
// pulse accumulator: event counter or gated time accumulator with two sticky flags
// assumes the input pin is asynchronous and the register master obeys one-cycle strobes
//
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps

// Overview of operation
// - eight-bit counter, mode bit chooses event counting or gated time accumulation.
// - gated mode counts a free-running divide-by-64 tick while pin is active.
// - count register is readable and writable at any time, any mode.
// - enable bit off disables accumulator, on enables it.
// - mode bit 0 is event counting, 1 is gated accumulation.
// - event mode: polarity 0 counts falling edges, 1 counts rising edges.
// - gated mode: polarity 0 stops on low input, 1 stops on high.
// - select bit 0 enables compare five, 1 enables capture four, exclusively.
// - reset leaves the count register untouched.
// - increments and software accesses never collide on the count.
// - overflow flag sets whenever count wraps from maximum to zero.
// - writing one to flag bit 5 clears overflow flag.
// - overflow irq enable gates request only, never the flag.
// - edge flag sets on each selected edge at the input pin while the enable bit is on.
// - writing one to flag bit 4 clears edge flag.
// - edge irq enable gates request only, never the flag.
// - each mask enable sits at its flag's bit position.
// - low four flag register bits read as zero.
module pacc_top
	import pacc_pkg::*;
(
	// clock and reset
	input  wire logic          core_clk_i,
	input  wire logic          rst_i,
	// register port
	input  wire pacc_pkg::pacc_bus_req_t bus_i,
	output logic [7:0]         rdata_o,
	// external pulse or gate
	input  wire logic          accumulator_input_pin_i,
	// requests and function select
	output logic               overflow_irq_o,
	output logic               edge_irq_o,
	output logic               output_compare_five_en_o,
	output logic               input_capture_four_en_o
);
	import pacc_pkg::*;

	pacc_state_t s_q;
	pacc_state_t s_d;

	logic       pin_edge;
	logic       pin_active;
	logic       tick;
	logic       inc;
	logic       sel_edge;
	logic [7:0] ctl_rd;
	logic [7:0] mask_rd;
	logic [7:0] flag_rd;

	function automatic logic [7:0] place_pair(input logic hi, input logic lo);
		logic [7:0] v;
		v = PACC_ZERO_BYTE;
		v[PACC_OVF_BIT]  = hi;
		v[PACC_EDGE_BIT] = lo;
		return v;
	endfunction : place_pair

	always_comb
	begin
		// only the synchronised stage feeds edge and gate logic
		pin_edge   = s_q.ctl_edge ? (s_q.pin_sync & ~s_q.pin_prev)
		                          : (~s_q.pin_sync & s_q.pin_prev);
		pin_active = s_q.ctl_edge ? ~s_q.pin_sync : s_q.pin_sync;
		tick       = (s_q.div == PACC_DIV_LAST);
		inc        = s_q.ctl_enable & (s_q.ctl_mode ? (tick & pin_active) : pin_edge);
		sel_edge   = s_q.ctl_enable & pin_edge;
		ctl_rd     = PACC_ZERO_BYTE;
		ctl_rd[PACC_CTL_ENABLE_BIT] = s_q.ctl_enable;
		ctl_rd[PACC_CTL_MODE_BIT]   = s_q.ctl_mode;
		ctl_rd[PACC_CTL_EDGE_BIT]   = s_q.ctl_edge;
		ctl_rd[PACC_CTL_CCSEL_BIT]  = s_q.ctl_ccsel;
		mask_rd    = place_pair(s_q.irq_ovf_en, s_q.irq_edge_en);
		flag_rd    = place_pair(s_q.flag_ovf, s_q.flag_edge);
	end

	always_comb
	begin
		s_d          = s_q;
		s_d.pin_meta = accumulator_input_pin_i;
		s_d.pin_sync = s_q.pin_meta;
		s_d.pin_prev = s_q.pin_sync;
		s_d.div      = 6'(s_q.div + 6'h1); // free running

		// software write wins over a same-cycle increment, no torn value
		if (bus_i.wr && bus_i.addr == PACC_OFF_COUNT)
		begin
			s_d.count = bus_i.wdata;
		end
		else if (inc)
		begin
			s_d.count = 8'(s_q.count + 8'h01);
		end

		if (bus_i.wr && bus_i.addr == PACC_OFF_CONTROL)
		begin
			s_d.ctl_enable = bus_i.wdata[PACC_CTL_ENABLE_BIT];
			s_d.ctl_mode   = bus_i.wdata[PACC_CTL_MODE_BIT];
			s_d.ctl_edge   = bus_i.wdata[PACC_CTL_EDGE_BIT];
			s_d.ctl_ccsel  = bus_i.wdata[PACC_CTL_CCSEL_BIT];
		end
		else if (bus_i.wr && bus_i.addr == PACC_OFF_MASK)
		begin
			s_d.irq_ovf_en  = bus_i.wdata[PACC_OVF_BIT];
			s_d.irq_edge_en = bus_i.wdata[PACC_EDGE_BIT];
		end
		else if (bus_i.wr && bus_i.addr == PACC_OFF_FLAG)
		begin
			// zero bits leave flags alone
			if (bus_i.wdata[PACC_OVF_BIT])
			begin
				s_d.flag_ovf = 1'b0;
			end
			if (bus_i.wdata[PACC_EDGE_BIT])
			begin
				s_d.flag_edge = 1'b0;
			end
		end

		// set beats clear in the same cycle
		if (inc && s_q.count == PACC_COUNT_MAX && !(bus_i.wr && bus_i.addr == PACC_OFF_COUNT))
		begin
			s_d.flag_ovf = 1'b1;
		end
		if (sel_edge && !s_q.ctl_mode)
		begin
			s_d.flag_edge = 1'b1;
		end
		// gated mode: the trailing edge of the active level is the selected edge
		if (s_q.ctl_enable && s_q.ctl_mode && (s_q.pin_prev ^ s_q.pin_sync)
			&& !pin_active)
		begin
			s_d.flag_edge = 1'b1;
		end

		if (bus_i.rd)
		begin
			if (bus_i.addr == PACC_OFF_CONTROL)
			begin
				s_d.rdata = ctl_rd;
			end
			else if (bus_i.addr == PACC_OFF_COUNT)
			begin
				s_d.rdata = s_q.count;
			end
			else if (bus_i.addr == PACC_OFF_MASK)
			begin
				s_d.rdata = mask_rd;
			end
			else
			begin
				s_d.rdata = flag_rd;
			end
		end
		else
		begin
			s_d.rdata = PACC_ZERO_BYTE;
		end
	end

	// count is kept out of the reset branch: its value survives reset
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			s_q.ctl_enable  <= PACC_CTL_RESET[PACC_CTL_ENABLE_BIT];
			s_q.ctl_mode    <= PACC_CTL_RESET[PACC_CTL_MODE_BIT];
			s_q.ctl_edge    <= PACC_CTL_RESET[PACC_CTL_EDGE_BIT];
			s_q.ctl_ccsel   <= PACC_CTL_RESET[PACC_CTL_CCSEL_BIT];
			s_q.irq_ovf_en  <= PACC_MASK_RESET[PACC_OVF_BIT];
			s_q.irq_edge_en <= PACC_MASK_RESET[PACC_EDGE_BIT];
			s_q.flag_ovf    <= 1'b0;
			s_q.flag_edge   <= 1'b0;
			s_q.div         <= 6'h00;
			s_q.pin_meta    <= 1'b0;
			s_q.pin_sync    <= 1'b0;
			s_q.pin_prev    <= 1'b0;
			s_q.rdata       <= PACC_ZERO_BYTE;
		end
		else
		begin
			s_q.ctl_enable  <= s_d.ctl_enable;
			s_q.ctl_mode    <= s_d.ctl_mode;
			s_q.ctl_edge    <= s_d.ctl_edge;
			s_q.ctl_ccsel   <= s_d.ctl_ccsel;
			s_q.irq_ovf_en  <= s_d.irq_ovf_en;
			s_q.irq_edge_en <= s_d.irq_edge_en;
			s_q.flag_ovf    <= s_d.flag_ovf;
			s_q.flag_edge   <= s_d.flag_edge;
			s_q.div         <= s_d.div;
			s_q.pin_meta    <= s_d.pin_meta;
			s_q.pin_sync    <= s_d.pin_sync;
			s_q.pin_prev    <= s_d.pin_prev;
			s_q.rdata       <= s_d.rdata;
			s_q.count       <= s_d.count;
		end
	end

	assign rdata_o                  = s_q.rdata;
	assign overflow_irq_o           = s_q.flag_ovf & s_q.irq_ovf_en;
	assign edge_irq_o               = s_q.flag_edge & s_q.irq_edge_en;
	assign output_compare_five_en_o = ~s_q.ctl_ccsel;
	assign input_capture_four_en_o  = s_q.ctl_ccsel;

	// assertions
	sequence s_wrap;
		inc && s_q.count == PACC_COUNT_MAX && !(bus_i.wr && bus_i.addr == PACC_OFF_COUNT);
	endsequence

	sequence s_flag_set;
		##1 s_q.flag_ovf && s_q.count == PACC_ZERO_BYTE;
	endsequence

	property p_wrap_sets_ovf;
		@(posedge core_clk_i) disable iff (rst_i)
		s_wrap |-> s_flag_set;
	endproperty
	a_wrap_sets_ovf: assert property (p_wrap_sets_ovf) else $error("wrap did not set overflow");

	property p_ovf_clear;
		@(posedge core_clk_i) disable iff (rst_i)
		(bus_i.wr && bus_i.addr == PACC_OFF_FLAG && bus_i.wdata[PACC_OVF_BIT] && !inc)
		|=> !s_q.flag_ovf;
	endproperty
	a_ovf_clear: assert property (p_ovf_clear) else $error("overflow flag not cleared");

	property p_edge_clear;
		@(posedge core_clk_i) disable iff (rst_i)
		(bus_i.wr && bus_i.addr == PACC_OFF_FLAG && bus_i.wdata[PACC_EDGE_BIT]
			&& s_q.pin_prev == s_q.pin_sync) |=> !s_q.flag_edge;
	endproperty
	a_edge_clear: assert property (p_edge_clear) else $error("edge flag not cleared");

	property p_zero_keeps;
		@(posedge core_clk_i) disable iff (rst_i)
		(bus_i.wr && bus_i.addr == PACC_OFF_FLAG && !bus_i.wdata[PACC_OVF_BIT]
			&& s_q.flag_ovf) |=> s_q.flag_ovf;
	endproperty
	a_zero_keeps: assert property (p_zero_keeps) else $error("zero write cleared flag");

	property p_disabled_holds;
		@(posedge core_clk_i) disable iff (rst_i)
		(!s_q.ctl_enable && !bus_i.wr) |=> $stable(s_q.count)
			&& (!s_q.flag_edge || $past(s_q.flag_edge));
	endproperty
	a_disabled_holds: assert property (p_disabled_holds) else $error("count moved while off");

	property p_gate_inhibit;
		@(posedge core_clk_i) disable iff (rst_i)
		(s_q.ctl_mode && !pin_active && !bus_i.wr) |=> s_q.count == $past(s_q.count);
	endproperty
	a_gate_inhibit: assert property (p_gate_inhibit) else $error("counted while gated off");

	property p_gate_rate;
		@(posedge core_clk_i) disable iff (rst_i)
		(s_q.ctl_enable && s_q.ctl_mode && !tick && !bus_i.wr)
		|=> s_q.count == $past(s_q.count);
	endproperty
	a_gate_rate: assert property (p_gate_rate) else $error("gated count off tick");

	property p_event_edge;
		@(posedge core_clk_i) disable iff (rst_i)
		(s_q.ctl_enable && !s_q.ctl_mode && s_q.ctl_edge && s_q.pin_sync && !s_q.pin_prev
			&& !bus_i.wr) |=> s_q.count == 8'($past(s_q.count) + 8'h01) && s_q.flag_edge;
	endproperty
	a_event_edge: assert property (p_event_edge) else $error("rising edge not counted");

	property p_irq_gate;
		@(posedge core_clk_i) disable iff (rst_i)
		edge_irq_o |-> s_q.flag_edge && s_q.irq_edge_en;
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("edge request without enable");

	property p_read_count;
		@(posedge core_clk_i) disable iff (rst_i)
		(bus_i.rd && bus_i.addr == PACC_OFF_COUNT) |=> rdata_o == $past(s_q.count);
	endproperty
	a_read_count: assert property (p_read_count) else $error("count readback wrong");

	property p_flag_low_zero;
		@(posedge core_clk_i) disable iff (rst_i)
		(bus_i.rd && bus_i.addr == PACC_OFF_FLAG) |=> rdata_o[3:0] == 4'h0;
	endproperty
	a_flag_low_zero: assert property (p_flag_low_zero) else $error("low flag bits set");

	sequence s_fall_seen;
		s_q.ctl_enable && !s_q.ctl_mode && !s_q.ctl_edge && !s_q.pin_sync
			&& s_q.pin_prev && !bus_i.wr;
	endsequence

	sequence s_counted_flagged;
		##1 s_q.count == 8'($past(s_q.count) + 8'h01) && s_q.flag_edge;
	endsequence

	property p_event_fall;
		@(posedge core_clk_i) disable iff (rst_i)
		s_fall_seen |-> s_counted_flagged;
	endproperty
	a_event_fall: assert property (p_event_fall) else $error("falling edge not counted");

	property p_gate_tick;
		@(posedge core_clk_i) disable iff (rst_i)
		(s_q.ctl_enable && s_q.ctl_mode && tick && pin_active && !bus_i.wr)
		|=> s_q.count == 8'($past(s_q.count) + 8'h01);
	endproperty
	a_gate_tick: assert property (p_gate_tick) else $error("gated tick not counted");

	property p_ovf_only_wrap;
		@(posedge core_clk_i) disable iff (rst_i)
		(!s_q.flag_ovf && !(inc && s_q.count == PACC_COUNT_MAX)) |=> !s_q.flag_ovf;
	endproperty
	a_ovf_only_wrap: assert property (p_ovf_only_wrap) else $error("overflow without wrap");

	property p_off_no_ovf;
		@(posedge core_clk_i) disable iff (rst_i)
		(!s_q.ctl_enable && !s_q.flag_ovf) |=> !s_q.flag_ovf;
	endproperty
	a_off_no_ovf: assert property (p_off_no_ovf) else $error("overflow set while off");

	property p_count_write;
		@(posedge core_clk_i) disable iff (rst_i)
		(bus_i.wr && bus_i.addr == PACC_OFF_COUNT) |=> s_q.count == $past(bus_i.wdata);
	endproperty
	a_count_write: assert property (p_count_write) else $error("count write lost");

	property p_mask_place;
		@(posedge core_clk_i) disable iff (rst_i)
		(bus_i.wr && bus_i.addr == PACC_OFF_MASK)
		|=> s_q.irq_ovf_en == $past(bus_i.wdata[PACC_OVF_BIT])
			&& s_q.irq_edge_en == $past(bus_i.wdata[PACC_EDGE_BIT]);
	endproperty
	a_mask_place: assert property (p_mask_place) else $error("mask bit misplaced");

	property p_mask_keeps_ovf;
		@(posedge core_clk_i) disable iff (rst_i)
		(bus_i.wr && bus_i.addr == PACC_OFF_MASK && !inc)
		|=> s_q.flag_ovf == $past(s_q.flag_ovf);
	endproperty
	a_mask_keeps_ovf: assert property (p_mask_keeps_ovf) else $error("mask moved flag");

	property p_mask_keeps_edge;
		@(posedge core_clk_i) disable iff (rst_i)
		(bus_i.wr && bus_i.addr == PACC_OFF_MASK && s_q.pin_prev == s_q.pin_sync)
		|=> s_q.flag_edge == $past(s_q.flag_edge);
	endproperty
	a_mask_keeps_edge: assert property (p_mask_keeps_edge) else $error("mask moved edge");

	property p_select;
		@(posedge core_clk_i) disable iff (rst_i)
		(bus_i.wr && bus_i.addr == PACC_OFF_CONTROL)
		|=> input_capture_four_en_o == $past(bus_i.wdata[PACC_CTL_CCSEL_BIT])
			&& output_compare_five_en_o != input_capture_four_en_o;
	endproperty
	a_select: assert property (p_select) else $error("function select wrong");

	property p_rdata_idle;
		@(posedge core_clk_i) disable iff (rst_i)
		!bus_i.rd |=> rdata_o == PACC_ZERO_BYTE;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read");

	property p_sync_first;
		@(posedge core_clk_i) disable iff (rst_i)
		(s_q.ctl_enable && !s_q.ctl_mode && s_q.pin_sync == s_q.pin_prev && !bus_i.wr)
		|=> $stable(s_q.count);
	endproperty
	a_sync_first: assert property (p_sync_first) else $error("count before sync edge");

	property p_zero_keeps_edge;
		@(posedge core_clk_i) disable iff (rst_i)
		(bus_i.wr && bus_i.addr == PACC_OFF_FLAG && !bus_i.wdata[PACC_EDGE_BIT]
			&& s_q.flag_edge) |=> s_q.flag_edge;
	endproperty
	a_zero_keeps_edge: assert property (p_zero_keeps_edge) else $error("zero cleared edge");

endmodule : pacc_top

// ===== testbench/pacc_pin_model.sv
// far-side model: external pulse or gate source on the accumulator input pin
// assumes the bench calls its tasks from one process at a time
`timescale 1ns/1ps
module pacc_pin_model (
	// clock of the sampling side
	input  wire logic core_clk_i,
	// driven pin
	output logic      accumulator_input_pin_o
);
	initial accumulator_input_pin_o = 1'b0;

	task automatic hold(input logic v, input int n);
		@(posedge core_clk_i);
		accumulator_input_pin_o <= v;
		repeat (n) @(posedge core_clk_i);
	endtask : hold

	// each level lasts at least two clocks so the sampling side keeps up
	task automatic pulses(input int n);
		repeat (n)
		begin
			hold(1'b1, 3);
			hold(1'b0, 3);
		end
	endtask : pulses
endmodule : pacc_pin_model

// ===== testbench/pacc_top_tb_top.sv
// bench top for the pulse accumulator: register tasks, read-data queue, verdict
// assumes pacc_top and the pin model are compiled before this file
`timescale 1ns/1ps
module pacc_top_tb_top;
	import pacc_pkg::*;
	logic          core_clk;
	logic          rst;
	pacc_bus_req_t bus;
	logic [7:0]    rdata;
	logic [7:0]    cnt;
	logic          pin;
	logic          ovf_irq;
	logic          edge_irq;
	logic          oc5_en;
	logic          ic4_en;
	logic          rd_was = 1'b0;
	int            n_fail;
	int            checks_done;
	int            n;
	logic [7:0]    exp_q[$];

	pacc_top dut_u (.core_clk_i(core_clk), .rst_i(rst), .bus_i(bus), .rdata_o(rdata),
		.accumulator_input_pin_i(pin), .overflow_irq_o(ovf_irq), .edge_irq_o(edge_irq),
		.output_compare_five_en_o(oc5_en), .input_capture_four_en_o(ic4_en));
	pacc_pin_model pin_u (.core_clk_i(core_clk), .accumulator_input_pin_o(pin));

	initial
	begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
			n_fail++;
		end
	endtask : chk

	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge core_clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge core_clk);
		bus.wr <= 1'b0;
	endtask : wr

	// the expected byte is noted first; the watcher pairs it with the answer
	task automatic rd(input logic [1:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		@(posedge core_clk);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge core_clk);
		bus.rd <= 1'b0;
	endtask : rd

	task automatic irqs(input logic [1:0] e);
		@(negedge core_clk);
		chk("irq", {6'h00, ovf_irq, edge_irq}, {6'h00, e});
	endtask : irqs

	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_sim

	always @(posedge core_clk) rd_was <= bus.rd;
	always @(negedge core_clk)
		if (rd_was === 1'b1)
			chk("rdata", rdata, exp_q.pop_front());

	initial
	begin
		#40000;
		n_fail++;
		end_sim();
	end

	initial
	begin
		rst = 1'b1;
		bus = '0;
		n_fail = 0;
		checks_done = 0;
		void'($urandom(32'h869f));
		repeat (5) @(posedge core_clk);
		rst <= 1'b0;
		rd(PACC_OFF_CONTROL, PACC_CTL_RESET);
		rd(PACC_OFF_MASK, PACC_MASK_RESET);
		rd(PACC_OFF_FLAG, 8'h00);
		wr(PACC_OFF_CONTROL, 8'h8F);
		rd(PACC_OFF_CONTROL, 8'h04);
		irqs(2'b00);
		chk("select", {6'h00, oc5_en, ic4_en}, 8'h01);
		wr(PACC_OFF_CONTROL, 8'h00);
		cnt = 8'($urandom);
		wr(PACC_OFF_COUNT, cnt);
		rd(PACC_OFF_COUNT, cnt);
		@(posedge core_clk);
		rst <= 1'b1;
		@(posedge core_clk);
		rst <= 1'b0;
		rd(PACC_OFF_COUNT, cnt);
		$display("registers and reset done");
		wr(PACC_OFF_MASK, 8'hFF);
		rd(PACC_OFF_MASK, 8'h30);
		wr(PACC_OFF_CONTROL, 8'h50);
		wr(PACC_OFF_COUNT, 8'hFE);
		pin_u.pulses(2);
		repeat (4) @(posedge core_clk);
		rd(PACC_OFF_COUNT, 8'h00);
		rd(PACC_OFF_FLAG, 8'h30);
		irqs(2'b11);
		wr(PACC_OFF_FLAG, 8'h00);
		rd(PACC_OFF_FLAG, 8'h30);
		wr(PACC_OFF_FLAG, 8'h20);
		rd(PACC_OFF_FLAG, 8'h10);
		irqs(2'b01);
		wr(PACC_OFF_FLAG, 8'h10);
		rd(PACC_OFF_FLAG, 8'h00);
		$display("rising edges and flags done");
		n = $urandom_range(5, 1);
		wr(PACC_OFF_CONTROL, 8'h40);
		wr(PACC_OFF_COUNT, 8'h00);
		pin_u.pulses(n);
		repeat (4) @(posedge core_clk);
		rd(PACC_OFF_COUNT, 8'(n));
		wr(PACC_OFF_MASK, 8'h00);
		irqs(2'b00);
		rd(PACC_OFF_FLAG, 8'h10);
		wr(PACC_OFF_FLAG, 8'h10);
		wr(PACC_OFF_CONTROL, 8'h10);
		pin_u.pulses(3);
		repeat (4) @(posedge core_clk);
		rd(PACC_OFF_COUNT, 8'(n));
		rd(PACC_OFF_FLAG, 8'h00);
		$display("falling edges and disable done");
		wr(PACC_OFF_CONTROL, 8'h60);
		wr(PACC_OFF_COUNT, 8'h00);
		// 192 sampled active cycles hold exactly three divider ticks, any phase
		pin_u.hold(1'b1, 191);
		pin_u.hold(1'b0, 8);
		rd(PACC_OFF_COUNT, 8'h03);
		rd(PACC_OFF_FLAG, 8'h10);
		// pin raised while off, so the polarity change opens no short window
		wr(PACC_OFF_CONTROL, 8'h30);
		pin_u.hold(1'b1, 4);
		wr(PACC_OFF_CONTROL, 8'h70);
		pin_u.hold(1'b1, 192);
		rd(PACC_OFF_COUNT, 8'h03);
		pin_u.hold(1'b0, 191);
		pin_u.hold(1'b1, 8);
		rd(PACC_OFF_COUNT, 8'h06);
		pin_u.hold(1'b0, 2);
		$display("gated accumulation done");
		repeat (10) @(posedge core_clk);
		end_sim();
	end
endmodule : pacc_top_tb_top
